// [src/sfcs_serial.sv]
// One serial channel with its format, bit order, clock select and module
// stop control, behind an AXI4-Lite slave. Assumes pins synchronous to aclk.
`timescale 1ns/1ns
`include "sfcs_params.svh"
module sfcs_serial #(
	parameter int CHANNEL = 0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic standby_soft,
	input wire logic standby_hard,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rxd,
	output logic txd,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	output logic channel2_halt,
	output logic channel1_halt,
	output logic channel0_halt
);
	generate
		if (CHANNEL < 0 || CHANNEL > 2)
		begin : g_bad_channel
			$error("CHANNEL must be 0, 1 or 2");
		end
	endgenerate

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
			r[i] = v[7 - i];
		return r;
	endfunction : rev8

	logic [7:0] mode_reg, div_reg, ctrl_reg, thr_reg, rhr_reg, order_reg;
	logic [15:0] mstop_reg;
	logic tdre_reg, tend_reg, rdrf_reg, orer_reg, fer_reg, per_reg;
	logic brk_reg, mpb_reg;
	logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg, rdata_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic do_wr, wr_b0, wr_b1, wr_hit, rd_hit, cfg_open, halt, chan_rst;
	logic [7:0] wd, stat_word;
	logic [31:0] rd_word;

	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign do_wr = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wd = w_data_reg[7:0];
	assign wr_b0 = do_wr && w_strb_reg[0];
	assign wr_b1 = do_wr && w_strb_reg[1];
	assign wr_hit = aw_addr_reg[1:0] == 2'h0 &&
		aw_addr_reg <= `SFCS_OFF_MSTOP;
	assign rd_hit = s_axi_araddr[1:0] == 2'h0 &&
		s_axi_araddr <= `SFCS_OFF_MSTOP;
	// Format and clock bits are frozen while either direction runs
	assign cfg_open = !ctrl_reg[`SFCS_C_TE] && !ctrl_reg[`SFCS_C_RE];
	assign halt = mstop_reg[`SFCS_HALT_BASE + CHANNEL];
	assign chan_rst = !aresetn || halt;
	assign channel2_halt = mstop_reg[`SFCS_HALT_BASE + 2];
	assign channel1_halt = mstop_reg[`SFCS_HALT_BASE + 1];
	assign channel0_halt = mstop_reg[`SFCS_HALT_BASE];

	// Address and data are latched separately so either may come first
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && !aw_held_reg)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			else if (do_wr)
				aw_held_reg <= 1'b0;
			if (s_axi_wvalid && !w_held_reg)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			else if (do_wr)
				w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `SFCS_RESP_OKAY;
		end
		else if (do_wr)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_hit ? `SFCS_RESP_OKAY : `SFCS_RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	always_comb
	begin
		stat_word = 8'h00;
		stat_word[`SFCS_S_TDRE] = tdre_reg;
		stat_word[`SFCS_S_RDRF] = rdrf_reg;
		stat_word[`SFCS_S_ORER] = orer_reg;
		stat_word[`SFCS_S_FER] = fer_reg;
		stat_word[`SFCS_S_PER] = per_reg;
		stat_word[`SFCS_S_TEND] = tend_reg;
		stat_word[`SFCS_S_BRK] = brk_reg;
		stat_word[`SFCS_S_MPB] = mpb_reg;
		case (s_axi_araddr)
			`SFCS_OFF_MODE: rd_word = {24'h0, mode_reg};
			`SFCS_OFF_DIV: rd_word = {24'h0, div_reg};
			`SFCS_OFF_CTRL: rd_word = {24'h0, ctrl_reg};
			`SFCS_OFF_TXH: rd_word = {24'h0, thr_reg};
			`SFCS_OFF_STAT: rd_word = {24'h0, stat_word};
			`SFCS_OFF_RXH: rd_word = {24'h0, rhr_reg};
			`SFCS_OFF_ORDER: rd_word = {24'h0, order_reg};
			`SFCS_OFF_MSTOP: rd_word = {16'h0, mstop_reg};
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= `SFCS_RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_reg)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_hit ? `SFCS_RESP_OKAY : `SFCS_RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_reg <= 8'h00;
			div_reg <= 8'h00;
			ctrl_reg <= 8'h00;
			thr_reg <= 8'h00;
		end
		else
		begin
			if (wr_b0 && cfg_open && aw_addr_reg == `SFCS_OFF_MODE)
				mode_reg <= wd;
			if (wr_b0 && cfg_open && aw_addr_reg == `SFCS_OFF_DIV)
				div_reg <= wd;
			// Enables always move; clock select only while both are off
			if (wr_b0 && aw_addr_reg == `SFCS_OFF_CTRL)
				ctrl_reg <= cfg_open ? wd :
					(wd & ~`SFCS_CTRL_CLKMASK) |
					(ctrl_reg & `SFCS_CTRL_CLKMASK);
			if (wr_b0 && aw_addr_reg == `SFCS_OFF_TXH)
				thr_reg <= wd;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby_soft || standby_hard || halt)
			order_reg <= `SFCS_ORDER_RST;
		else if (wr_b0 && cfg_open && aw_addr_reg == `SFCS_OFF_ORDER)
			order_reg <= (wd & `SFCS_ORDER_WMASK) |
				(`SFCS_ORDER_RST & ~`SFCS_ORDER_WMASK);
	end

	// Software standby leaves the halt bits as they were
	always_ff @(posedge aclk)
	begin
		if (!aresetn || standby_hard)
			mstop_reg <= `SFCS_MSTOP_RST;
		else if (aw_addr_reg == `SFCS_OFF_MSTOP && wr_hit)
		begin
			if (wr_b0)
				mstop_reg[7:0] <= wd;
			if (wr_b1)
				mstop_reg[15:8] <= w_data_reg[15:8];
		end
	end

	logic cs, ext, te, re, char7, use_par, use_mp, rev, run;
	logic [2:0] last;
	logic [6:0] pre_cnt_reg, pre_lim;
	logic [7:0] div_cnt_reg, load_val;
	logic brg_tick, sck_d_reg, sck_int_reg, tick16, bnd, sfall, srise;
	logic [3:0] phase_reg;
	sfcs_pkg::sfcs_tx_e tx_state_reg;

	assign cs = mode_reg[`SFCS_M_CA];
	assign ext = ctrl_reg[`SFCS_C_CLOCK_SOURCE_SEL];
	assign te = ctrl_reg[`SFCS_C_TE];
	assign re = ctrl_reg[`SFCS_C_RE];
	assign char7 = !cs && mode_reg[`SFCS_M_CHR];
	assign use_mp = !cs && mode_reg[`SFCS_M_MP];
	assign use_par = !cs && !mode_reg[`SFCS_M_MP] &&
		mode_reg[`SFCS_M_PE];
	assign last = char7 ? `SFCS_LAST7 : `SFCS_LAST8;
	assign rev = order_reg[`SFCS_O_DIR] && !char7;
	assign load_val = rev ? rev8(thr_reg) :
		{thr_reg[7] && !char7, thr_reg[6:0]};

	always_comb
	begin
		case (mode_reg[1:0])
			2'h0: pre_lim = `SFCS_PRE_LIM0;
			2'h1: pre_lim = `SFCS_PRE_LIM1;
			2'h2: pre_lim = `SFCS_PRE_LIM2;
			default: pre_lim = `SFCS_PRE_LIM3;
		endcase
	end

	// One tick per sixteenth bit (async) or per half bit (sync)
	assign brg_tick = pre_cnt_reg == pre_lim &&
		div_cnt_reg == div_reg;
	always_ff @(posedge aclk)
	begin
		if (chan_rst || !(te || re))
		begin
			pre_cnt_reg <= 7'h00;
			div_cnt_reg <= 8'h00;
		end
		else if (pre_cnt_reg == pre_lim)
		begin
			pre_cnt_reg <= 7'h00;
			div_cnt_reg <= brg_tick ? 8'h00 : div_cnt_reg + 8'h01;
		end
		else
			pre_cnt_reg <= pre_cnt_reg + 7'h01;
	end

	assign run = tx_state_reg != sfcs_pkg::SFCS_TX_IDLE ||
		(te && !tdre_reg) || re;
	assign tick16 = ext ? (sck_in && !sck_d_reg) : brg_tick;
	assign bnd = tick16 && phase_reg == `SFCS_LAST_SUB;
	assign sfall = ext ? (!sck_in && sck_d_reg) :
		(brg_tick && sck_int_reg && run);
	assign srise = ext ? (sck_in && !sck_d_reg) :
		(brg_tick && !sck_int_reg);

	always_ff @(posedge aclk)
	begin
		if (chan_rst)
		begin
			sck_d_reg <= 1'b1;
			sck_int_reg <= 1'b1;
			phase_reg <= 4'h0;
			sck_out <= 1'b1;
			sck_oe <= 1'b0;
		end
		else
		begin
			sck_d_reg <= sck_in;
			// Stops only with the line high, so no stray edge is seen
			if (!cs || ext)
				sck_int_reg <= 1'b1;
			else if (brg_tick && (run || !sck_int_reg))
				sck_int_reg <= !sck_int_reg;
			if (tick16)
				phase_reg <= phase_reg + 4'h1;
			// Async output rises mid-bit
			sck_out <= cs ? sck_int_reg : phase_reg[3];
			sck_oe <= !ext && (cs || ctrl_reg[`SFCS_C_CLOCK_PIN_OUT_EN]);
		end
	end

	logic [7:0] tx_sh_reg;
	logic [2:0] tx_cnt_reg;
	logic tx_par_reg, tx_stops_reg, pending, tx_load, tx_end, wr_thr;

	assign pending = te && !tdre_reg;
	assign wr_thr = wr_b0 && aw_addr_reg == `SFCS_OFF_TXH;
	assign tx_load = pending && (cs ?
		(tx_state_reg == sfcs_pkg::SFCS_TX_IDLE && sfall) :
		(bnd && (tx_state_reg == sfcs_pkg::SFCS_TX_IDLE ||
		(tx_state_reg == sfcs_pkg::SFCS_TX_STOP && !tx_stops_reg))));
	assign tx_end = cs ?
		(tx_state_reg == sfcs_pkg::SFCS_TX_DATA && srise &&
		tx_cnt_reg == `SFCS_LAST8 && !pending) :
		(bnd && tx_state_reg == sfcs_pkg::SFCS_TX_STOP &&
		!tx_stops_reg && !pending);

	always_ff @(posedge aclk)
	begin
		if (chan_rst || !te)
		begin
			tx_state_reg <= sfcs_pkg::SFCS_TX_IDLE;
			txd <= 1'b1;
			tx_sh_reg <= 8'h00;
			tx_cnt_reg <= 3'h0;
			tx_par_reg <= 1'b0;
			tx_stops_reg <= 1'b0;
		end
		else if (tx_load && !cs)
		begin
			tx_state_reg <= sfcs_pkg::SFCS_TX_START;
			txd <= 1'b0;
			tx_sh_reg <= load_val;
			tx_par_reg <= ^load_val ^ mode_reg[`SFCS_M_ODD];
			tx_stops_reg <= mode_reg[`SFCS_M_STOP];
		end
		else if (tx_load)
		begin
			tx_state_reg <= sfcs_pkg::SFCS_TX_DATA;
			txd <= load_val[0];
			tx_sh_reg <= {1'b0, load_val[7:1]};
			tx_cnt_reg <= 3'h0;
		end
		else if (cs)
		begin
			if (tx_state_reg == sfcs_pkg::SFCS_TX_DATA)
			begin
				if (srise && tx_cnt_reg == `SFCS_LAST8)
					tx_state_reg <= sfcs_pkg::SFCS_TX_IDLE;
				else if (sfall && tx_cnt_reg != `SFCS_LAST8)
				begin
					txd <= tx_sh_reg[0];
					tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
					tx_cnt_reg <= tx_cnt_reg + 3'h1;
				end
			end
		end
		else if (bnd)
		begin
			case (tx_state_reg)
				sfcs_pkg::SFCS_TX_START:
				begin
					tx_state_reg <= sfcs_pkg::SFCS_TX_DATA;
					txd <= tx_sh_reg[0];
					tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
					tx_cnt_reg <= 3'h0;
				end
				sfcs_pkg::SFCS_TX_DATA:
					if (tx_cnt_reg != last)
					begin
						txd <= tx_sh_reg[0];
						tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
						tx_cnt_reg <= tx_cnt_reg + 3'h1;
					end
					else if (use_par || use_mp)
					begin
						tx_state_reg <= sfcs_pkg::SFCS_TX_PAR;
						txd <= use_mp ? ctrl_reg[`SFCS_C_MPBT] :
							tx_par_reg;
					end
					else
					begin
						tx_state_reg <= sfcs_pkg::SFCS_TX_STOP;
						txd <= 1'b1;
					end
				sfcs_pkg::SFCS_TX_PAR:
				begin
					tx_state_reg <= sfcs_pkg::SFCS_TX_STOP;
					txd <= 1'b1;
				end
				sfcs_pkg::SFCS_TX_STOP:
					if (tx_stops_reg)
						tx_stops_reg <= 1'b0;
					else
						tx_state_reg <= sfcs_pkg::SFCS_TX_IDLE;
				default:
					tx_state_reg <= sfcs_pkg::SFCS_TX_IDLE;
			endcase
		end
	end

	// A holding write is new data, so it beats the hardware set
	always_ff @(posedge aclk)
	begin
		if (chan_rst)
		begin
			tdre_reg <= 1'b1;
			tend_reg <= 1'b1;
		end
		else
		begin
			if (wr_thr)
				tdre_reg <= 1'b0;
			else if (tx_load || !te)
				tdre_reg <= 1'b1;
			if (wr_thr)
				tend_reg <= 1'b0;
			else if (tx_end || !te)
				tend_reg <= 1'b1;
		end
	end

	sfcs_pkg::sfcs_rx_e rx_state_reg;
	logic [3:0] rx_sub_reg;
	logic [2:0] rx_cnt_reg;
	logic [7:0] rx_sh_reg, rx_word, rx_final;
	logic rx_pbit_reg, rx_en, rx_smp, rx_done, rx_ferr, rx_perr, wr_stat;

	assign rx_en = re && !(orer_reg || fer_reg || per_reg);
	assign rx_smp = tick16 && rx_sub_reg == `SFCS_SAMPLE_SUB;
	// Sync ends on the eighth rise, before that bit is shifted in
	assign rx_word = cs ? {rxd, rx_sh_reg[7:1]} :
		char7 ? {1'b0, rx_sh_reg[7:1]} : rx_sh_reg;
	assign rx_final = rev ? rev8(rx_word) : rx_word;
	assign rx_done = cs ? (rx_en && srise && rx_cnt_reg == `SFCS_LAST8) :
		(rx_state_reg == sfcs_pkg::SFCS_RX_STOP && rx_smp);
	// Synchronous mode has no stop or parity to check
	assign rx_ferr = !cs && !rxd;
	assign rx_perr = use_par &&
		(^rx_word ^ mode_reg[`SFCS_M_ODD] ^ rx_pbit_reg);
	assign wr_stat = wr_b0 && aw_addr_reg == `SFCS_OFF_STAT;

	always_ff @(posedge aclk)
	begin
		if (chan_rst || !rx_en)
		begin
			rx_state_reg <= sfcs_pkg::SFCS_RX_IDLE;
			rx_sub_reg <= 4'h0;
			rx_cnt_reg <= 3'h0;
			rx_sh_reg <= 8'h00;
			rx_pbit_reg <= 1'b0;
		end
		else if (cs)
		begin
			if (srise)
			begin
				rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
				rx_cnt_reg <= rx_cnt_reg + 3'h1;
			end
		end
		else if (tick16)
		begin
			rx_sub_reg <= rx_sub_reg + 4'h1;
			case (rx_state_reg)
				sfcs_pkg::SFCS_RX_IDLE:
					if (!rxd)
					begin
						rx_state_reg <= sfcs_pkg::SFCS_RX_START;
						rx_sub_reg <= 4'h1;
					end
				sfcs_pkg::SFCS_RX_START:
					if (rx_smp)
					begin
						rx_state_reg <= rxd ? sfcs_pkg::SFCS_RX_IDLE :
							sfcs_pkg::SFCS_RX_DATA;
						rx_cnt_reg <= 3'h0;
					end
				sfcs_pkg::SFCS_RX_DATA:
					if (rx_smp)
					begin
						rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
						rx_cnt_reg <= rx_cnt_reg + 3'h1;
						if (rx_cnt_reg == last)
							rx_state_reg <= (use_par || use_mp) ?
								sfcs_pkg::SFCS_RX_PAR :
								sfcs_pkg::SFCS_RX_STOP;
					end
				sfcs_pkg::SFCS_RX_PAR:
					if (rx_smp)
					begin
						rx_pbit_reg <= rxd;
						rx_state_reg <= sfcs_pkg::SFCS_RX_STOP;
					end
				sfcs_pkg::SFCS_RX_STOP:
					if (rx_smp)
						rx_state_reg <= sfcs_pkg::SFCS_RX_IDLE;
				default:
					rx_state_reg <= sfcs_pkg::SFCS_RX_IDLE;
			endcase
		end
	end

	// Flags: the hardware set beats a software clear in the same cycle
	always_ff @(posedge aclk)
	begin
		if (chan_rst)
		begin
			rdrf_reg <= 1'b0;
			orer_reg <= 1'b0;
			fer_reg <= 1'b0;
			per_reg <= 1'b0;
			brk_reg <= 1'b0;
			mpb_reg <= 1'b0;
			rhr_reg <= 8'h00;
		end
		else
		begin
			if (rx_done && !rdrf_reg && !rx_ferr && !rx_perr)
				rdrf_reg <= 1'b1;
			else if (wr_stat && !wd[`SFCS_S_RDRF])
				rdrf_reg <= 1'b0;
			if (rx_done && rdrf_reg)
				orer_reg <= 1'b1;
			else if (wr_stat && !wd[`SFCS_S_ORER])
				orer_reg <= 1'b0;
			if (rx_done && !rdrf_reg && rx_ferr)
				fer_reg <= 1'b1;
			else if (wr_stat && !wd[`SFCS_S_FER])
				fer_reg <= 1'b0;
			if (rx_done && !rdrf_reg && rx_perr)
				per_reg <= 1'b1;
			else if (wr_stat && !wd[`SFCS_S_PER])
				per_reg <= 1'b0;
			if (rx_done && !rdrf_reg && rx_ferr && rx_word == 8'h00)
				brk_reg <= 1'b1;
			else if (wr_stat && !wd[`SFCS_S_BRK])
				brk_reg <= 1'b0;
			if (rx_done && !rdrf_reg)
			begin
				rhr_reg <= rx_final;
				mpb_reg <= use_mp && rx_pbit_reg;
			end
		end
	end
endmodule : sfcs_serial

// [pkg/sfcs_params.svh]
// Register offsets, field positions, reset values and timing counts of the
// serial format and clock select block. Assumes a 32-bit AXI4-Lite bus.
`ifndef SFCS_PARAMS_SVH
`define SFCS_PARAMS_SVH
`define SFCS_OFF_MODE 8'h00
`define SFCS_OFF_DIV 8'h04
`define SFCS_OFF_CTRL 8'h08
`define SFCS_OFF_TXH 8'h0c
`define SFCS_OFF_STAT 8'h10
`define SFCS_OFF_RXH 8'h14
`define SFCS_OFF_ORDER 8'h18
`define SFCS_OFF_MSTOP 8'h1c
`define SFCS_M_CA 7
`define SFCS_M_CHR 6
`define SFCS_M_PE 5
`define SFCS_M_ODD 4
`define SFCS_M_STOP 3
`define SFCS_M_MP 2
`define SFCS_C_TE 5
`define SFCS_C_RE 4
`define SFCS_C_MPBT 3
`define SFCS_C_CLOCK_SOURCE_SEL 1
`define SFCS_C_CLOCK_PIN_OUT_EN 0
`define SFCS_O_DIR 3
`define SFCS_S_TDRE 7
`define SFCS_S_RDRF 6
`define SFCS_S_ORER 5
`define SFCS_S_FER 4
`define SFCS_S_PER 3
`define SFCS_S_TEND 2
`define SFCS_S_BRK 1
`define SFCS_S_MPB 0
`define SFCS_HALT_BASE 5
`define SFCS_ORDER_RST 8'hf2
`define SFCS_ORDER_WMASK 8'h0d
`define SFCS_MSTOP_RST 16'h3fff
`define SFCS_CTRL_CLKMASK 8'h03
`define SFCS_PRE_LIM0 7'h01
`define SFCS_PRE_LIM1 7'h07
`define SFCS_PRE_LIM2 7'h1f
`define SFCS_PRE_LIM3 7'h7f
`define SFCS_SAMPLE_SUB 4'h7
`define SFCS_LAST_SUB 4'hf
`define SFCS_LAST8 3'h7
`define SFCS_LAST7 3'h6
`define SFCS_RESP_OKAY 2'h0
`define SFCS_RESP_SLVERR 2'h2
`endif

// [pkg/sfcs_pkg.sv]
// Types of the serial format and clock select block.
// Assumes sfcs_params.svh supplies the numeric constants.
package sfcs_pkg;
	typedef enum logic [4:0] {
		SFCS_TX_IDLE = 5'h01,
		SFCS_TX_START = 5'h02,
		SFCS_TX_DATA = 5'h04,
		SFCS_TX_PAR = 5'h08,
		SFCS_TX_STOP = 5'h10
	} sfcs_tx_e;
	typedef enum logic [4:0] {
		SFCS_RX_IDLE = 5'h01,
		SFCS_RX_START = 5'h02,
		SFCS_RX_DATA = 5'h04,
		SFCS_RX_PAR = 5'h08,
		SFCS_RX_STOP = 5'h10
	} sfcs_rx_e;
endpackage : sfcs_pkg

// [sim/sfcs_serial_asserts.sv]
// Checker of bus answers, reset, standby and halt behaviour of sfcs_serial.
// Assumes it is bound to sfcs_serial and sees only its ports.
`timescale 1ns/1ns
`include "sfcs_params.svh"
module sfcs_serial_asserts #(
	parameter int CHANNEL = 0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic standby_soft,
	input wire logic standby_hard,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic txd,
	input wire logic sck_oe,
	input wire logic channel2_halt,
	input wire logic channel1_halt,
	input wire logic channel0_halt
);
	logic [2:0] halts;
	assign halts = {channel2_halt, channel1_halt, channel0_halt};
	default clocking dcb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	a_out_reset: assert property ($rose(aresetn) |-> &halts && txd && !sck_oe)
		else $error("outputs not at reset state");
	a_hard_standby: assert property (standby_hard |=> &halts)
		else $error("halt bits not reloaded");
	a_soft_keep: assert property (standby_soft && !standby_hard
		|=> $stable(halts) || $rose(s_axi_bvalid))
		else $error("halt bits lost in soft standby");
	// Two cycles let the held channel reset reach the pins
	a_halt_quiet: assert property (halts[CHANNEL] [*2] |-> txd && !sck_oe)
		else $error("halted channel still active");
	// Held address and data land one edge before bvalid rises
	a_write_resp: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	a_read_resp: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	a_bad_addr: assert property (rd_taken ##0 (s_axi_araddr > 8'h1c
		|| s_axi_araddr[1:0] != 2'h0)
		|=> s_axi_rresp == `SFCS_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_order_ones: assert property (rd_taken
		##0 (s_axi_araddr == `SFCS_OFF_ORDER)
		|=> s_axi_rdata[7:4] == 4'hf && s_axi_rdata[1])
		else $error("reserved order bits not one");
	a_halt_read: assert property (rd_taken
		##0 (s_axi_araddr == `SFCS_OFF_MSTOP)
		|=> s_axi_rdata[7:5] == $past(halts))
		else $error("halt pins differ from register");
endmodule : sfcs_serial_asserts
bind sfcs_serial sfcs_serial_asserts #(.CHANNEL(CHANNEL)) u_chk (
	.aclk(aclk), .aresetn(aresetn), .standby_soft(standby_soft),
	.standby_hard(standby_hard), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .txd(txd),
	.sck_oe(sck_oe), .channel2_halt(channel2_halt),
	.channel1_halt(channel1_halt), .channel0_halt(channel0_halt)
);

// [sim/sfcs_remote.sv]
// Remote serial device that sends asynchronous frames to the block.
// Assumes the bit period is BIT_CYC aclk cycles (divisor and prescale 0),
// and BIT_CYC of 32, so that sck_in rises sixteen times per bit.
`timescale 1ns/1ns
module sfcs_remote #(
	parameter int BIT_CYC = 32
) (
	input wire logic aclk,
	output logic rxd,
	output logic sck_in
);
	// External clock may run free; stopping it mid-operation is unsafe
	initial sck_in = 1'b0;
	always @(posedge aclk)
		sck_in <= ~sck_in;
	// Line is pulled up, so it rests at mark between frames
	initial rxd = 1'b1;
	task automatic send(input logic [11:0] f, input int n);
		for (int i = 0; i < n; i++)
		begin
			rxd <= f[i];
			repeat (BIT_CYC) @(posedge aclk);
		end
		rxd <= 1'b1;
	endtask : send
endmodule : sfcs_remote

// [sim/sfcs_serial_tb.sv]
// Self-checking bench of sfcs_serial: registers, standby, pin and frames.
// Assumes the checker is bound in and sfcs_remote feeds the receive line.
`timescale 1ns/1ns
`include "sfcs_params.svh"
module sfcs_serial_tb;
	localparam logic [7:0] CORNER [4] = '{8'h00, 8'h40, 8'h2c, 8'h34};
	localparam logic [31:0] MS_EXP [3] = '{32'h1234, 32'h3fff, 32'h0040};
	logic aclk, aresetn, standby_soft, standby_hard, sck_in;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, rxd, txd, sck_oe, sck_out;
	logic channel2_halt, channel1_halt, channel0_halt;
	logic [2:0] halts;
	int fail_count, num_checks;
	assign halts = {channel2_halt, channel1_halt, channel0_halt};
	sfcs_serial #(.CHANNEL(1)) uut (
		.aclk(aclk), .aresetn(aresetn), .standby_soft(standby_soft),
		.standby_hard(standby_hard), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.rxd(rxd), .txd(txd), .sck_in(sck_in), .sck_out(sck_out),
		.sck_oe(sck_oe), .channel2_halt(channel2_halt),
		.channel1_halt(channel1_halt), .channel0_halt(channel0_halt)
	);
	sfcs_remote peer (.aclk(aclk), .rxd(rxd), .sck_in(sck_in));
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// Tests take about 4500 cycles; over six times that means a hang
	initial
	begin
		repeat (30000) @(posedge aclk);
		fail_count++;
		end_sim();
	end
	task automatic end_sim();
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %0t: reg %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_frame(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error %0t: frame %h expected %h", $time, got, exp);
		end
	endtask : chk_frame
	// Trailing edge keeps the next call from driving in the same step
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'h3;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		wr_resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		rd_data = s_axi_rdata;
		rd_resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_rd
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		axi_rd(a);
		chk_reg(rd_data, exp);
	endtask : rd_chk
	// Expected line bits, start first; unused upper bits read as mark
	function automatic logic [11:0] frame_of(input logic [7:0] d,
		input logic [7:0] m, input logic dir, input logic mpb, output int n);
		logic [11:0] f;
		logic [7:0] x;
		x = m[6] ? {1'b0, d[6:0]} : d;
		f = 12'hffe;
		n = 1;
		for (int i = 0; i < 8 - m[6]; i++)
		begin
			f[n] = (dir && !m[6]) ? x[7 - i] : x[i];
			n++;
		end
		if (m[2] || m[5])
		begin
			f[n] = m[2] ? mpb : ^x ^ m[4];
			n++;
		end
		n += 1 + m[3];
		return f;
	endfunction : frame_of
	task automatic grab(input int n, output logic [11:0] f);
		f = 12'hfff;
		for (int t = 0; t < 99 && txd === 1'b1; t++)
			@(posedge aclk);
		repeat (16) @(posedge aclk);
		for (int i = 0; i < n; i++)
		begin
			f[i] = txd;
			repeat (32) @(posedge aclk);
		end
	endtask : grab
	initial
	begin
		logic [31:0] v;
		logic [11:0] f, e;
		logic [7:0] m;
		logic dir;
		int n;
		{aresetn, standby_soft, standby_hard} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		fail_count = 0;
		num_checks = 0;
		void'($urandom(31107));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_reg({29'h0, halts}, 32'h7);
		rd_chk(`SFCS_OFF_ORDER, 32'hf2);
		rd_chk(`SFCS_OFF_MSTOP, 32'h3fff);
		for (int i = 0; i < 3; i++)
		begin
			v = {16'h0, 16'($urandom)};
			axi_wr(`SFCS_OFF_MSTOP, v);
			rd_chk(`SFCS_OFF_MSTOP, v);
			chk_reg({29'h0, halts}, {29'h0, v[7:5]});
		end
		for (int i = 0; i < 3; i++)
		begin
			axi_wr(`SFCS_OFF_MSTOP, 32'h1234);
			axi_wr(`SFCS_OFF_ORDER, 32'h0d);
			rd_chk(`SFCS_OFF_ORDER, 32'hff);
			standby_soft <= (i == 0);
			standby_hard <= (i == 1);
			if (i == 2)
				axi_wr(`SFCS_OFF_MSTOP, 32'h0040);
			else
				repeat (2) @(posedge aclk);
			standby_soft <= 1'b0;
			standby_hard <= 1'b0;
			rd_chk(`SFCS_OFF_ORDER, 32'hf2);
			rd_chk(`SFCS_OFF_MSTOP, MS_EXP[i]);
		end
		axi_wr(`SFCS_OFF_MSTOP, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			v = $urandom;
			axi_wr(`SFCS_OFF_ORDER, v);
			rd_chk(`SFCS_OFF_ORDER, {24'h0, v[7:0] & 8'h0d | 8'hf2});
		end
		axi_rd(8'h20);
		chk_reg({30'h0, rd_resp}, {30'h0, `SFCS_RESP_SLVERR});
		axi_wr(8'h06, 32'hff);
		chk_reg({30'h0, wr_resp}, {30'h0, `SFCS_RESP_SLVERR});
		for (int i = 0; i < 8; i++)
		begin
			axi_wr(`SFCS_OFF_MODE, {24'h0, i[2], 7'h0});
			axi_wr(`SFCS_OFF_CTRL, {30'h0, i[1:0]});
			chk_reg({31'h0, sck_oe},
				{31'h0, i[2] ? !i[1] : (i[1:0] == 2'h1)});
			if (i[2])
				chk_reg({31'h0, sck_out}, 32'h1);
		end
		axi_wr(`SFCS_OFF_DIV, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			v = $urandom;
			m = (i < 4) ? CORNER[i] : v[23:16] & 8'h7c;
			dir = (i < 2) | v[0];
			axi_wr(`SFCS_OFF_ORDER, {28'h0, dir, 3'h0});
			axi_wr(`SFCS_OFF_MODE, {24'h0, m});
			axi_wr(`SFCS_OFF_CTRL, {26'h0, 2'h2, v[1], 3'h0});
			axi_wr(`SFCS_OFF_MODE, {24'h0, ~m});
			rd_chk(`SFCS_OFF_MODE, {24'h0, m});
			axi_wr(`SFCS_OFF_TXH, {24'h0, v[15:8]});
			e = frame_of(v[15:8], m, dir, v[1], n);
			grab(n, f);
			chk_frame(f, e);
			axi_wr(`SFCS_OFF_CTRL, 32'h0);
		end
		axi_wr(`SFCS_OFF_MODE, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			v = $urandom;
			v[7:0] = (i == 2) ? 8'h00 : v[7:0];
			axi_wr(`SFCS_OFF_ORDER, {28'h0, i[0], 3'h0});
			axi_wr(`SFCS_OFF_CTRL, i[0] ? 32'h12 : 32'h10);
			f = frame_of(v[7:0], 8'h0, i[0], 1'b0, n);
			f[9] = (i != 2);
			peer.send(f, n);
			axi_rd(`SFCS_OFF_STAT);
			chk_reg(rd_data & 32'h7a, (i == 2) ? 32'h12 : 32'h40);
			if (i != 2)
				rd_chk(`SFCS_OFF_RXH, {24'h0, v[7:0]});
			axi_wr(`SFCS_OFF_STAT, 32'h0);
			axi_wr(`SFCS_OFF_CTRL, 32'h0);
		end
		end_sim();
	end
endmodule : sfcs_serial_tb
